// file: adcs_sequencer.sv
/*
 * Start detection, sample and successive-approximation sequencing, busy and interrupt flags, result bytes.
 * Assumes control inputs come from software registers on sys_clk and the comparator is asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
module adcs_sequencer (
    // Clock and reset
    input  wire logic                                   sys_clk,
    input  wire logic                                   resetn,
    // Software control
    input  wire adcs_pkg::adcs_cfg_s                    cfg,
    input  wire logic                                   startBit,
    input  wire logic                                   irqClear,
    // Software status
    output logic                                        busyFlag,
    output logic                                        irqFlag,
    output logic                                        irqOut,
    output logic                                        clkRangeOk,
    output logic [adcs_pkg::BYTE_WIDTH-1:0]             resultHigh,
    output logic [adcs_pkg::BYTE_WIDTH-1:0]             resultLow,
    // Analog front end
    input  wire logic                                   compIn,
    output adcs_pkg::adcs_analog_s                      analog
);

    // ****************************************************************
    // Reset release and comparator synchroniser
    // ****************************************************************
    logic rstMeta;
    logic rstn;
    logic compMeta;
    logic compSync;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta <= 1'b0;
            rstn    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstn    <= rstMeta;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            compMeta <= 1'b0;
            compSync <= 1'b0;
        end else begin
            compMeta <= compIn;
            compSync <= compMeta;
        end
    end

    // ****************************************************************
    // Start detection and sequencing
    // ****************************************************************
    adcs_pkg::adcs_state_e                state;
    logic                                 armed;
    logic                                 trigger;
    logic                                 tick;
    logic                                 done;
    logic [adcs_pkg::TICK_CNT_WIDTH-1:0]  sampleCnt;
    logic [adcs_pkg::BIT_IDX_WIDTH-1:0]   bitIdx;
    logic [adcs_pkg::RESULT_WIDTH-1:0]    sar;
    logic [adcs_pkg::RESULT_WIDTH-1:0]    finalCode;

    function automatic logic [adcs_pkg::RESULT_WIDTH-1:0] bit_mask(
        input logic [adcs_pkg::BIT_IDX_WIDTH-1:0] idx);
        bit_mask = adcs_pkg::RESULT_WIDTH'(12'h001 << idx);
    endfunction

    // Start is only armed while idle and powered, so a pulse seen during a conversion is dropped.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            armed <= 1'b0;
        end else if (startBit && !busyFlag && cfg.powerEnable) begin
            armed <= 1'b1;
        end else if (!startBit || busyFlag || !cfg.powerEnable) begin
            armed <= 1'b0;
        end
    end

    assign trigger = armed && !startBit && !busyFlag && cfg.powerEnable;
    assign done    = (state == adcs_pkg::ST_CONVERT) && tick && (bitIdx == adcs_pkg::LSB_INDEX);
    assign finalCode = compSync ? (sar | bit_mask(bitIdx)) : sar;

    adcs_clk_div u_clk_div (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (busyFlag),
        .divSel  (cfg.divSel),
        .tick    (tick)
    );

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state     <= adcs_pkg::ST_IDLE;
            sampleCnt <= '0;
            bitIdx    <= adcs_pkg::MSB_INDEX;
        end else if (!cfg.powerEnable) begin
            // Losing power before the last conversion clock abandons it; no result and no request follow.
            state     <= adcs_pkg::ST_IDLE;
            sampleCnt <= '0;
            bitIdx    <= adcs_pkg::MSB_INDEX;
        end else begin
            case (state)
                adcs_pkg::ST_IDLE: begin
                    if (trigger) begin
                        state     <= adcs_pkg::ST_SAMPLE;
                        sampleCnt <= '0;
                    end
                end
                adcs_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        if (sampleCnt == adcs_pkg::SAMPLE_TICKS - 5'h01) begin
                            state  <= adcs_pkg::ST_CONVERT;
                            bitIdx <= adcs_pkg::MSB_INDEX;
                        end else begin
                            sampleCnt <= sampleCnt + 5'h01;
                        end
                    end
                end
                adcs_pkg::ST_CONVERT: begin
                    if (done) begin
                        state <= adcs_pkg::ST_IDLE;
                    end else if (tick) begin
                        bitIdx <= bitIdx - 4'h1;
                    end
                end
                default: begin
                    state <= adcs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // One bit is decided per conversion clock, most significant first.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sar <= adcs_pkg::RESULT_RESET;
        end else if (trigger) begin
            sar <= adcs_pkg::RESULT_RESET;
        end else if ((state == adcs_pkg::ST_CONVERT) && tick) begin
            sar <= finalCode;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busyFlag <= 1'b0;
        end else if (trigger) begin
            busyFlag <= 1'b1;
        end else if (done || !cfg.powerEnable) begin
            busyFlag <= 1'b0;
        end
    end

    // ****************************************************************
    // Result, interrupt and status
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            resultHigh <= '0;
            resultLow  <= '0;
        end else if (done) begin
            resultHigh <= adcs_pkg::BYTE_WIDTH'(finalCode >> adcs_pkg::BYTE_WIDTH);
            resultLow  <= finalCode[adcs_pkg::BYTE_WIDTH-1:0];
        end
    end

    // A completion in the same cycle as a software clear keeps the request.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irqFlag <= 1'b0;
        end else if (done) begin
            irqFlag <= 1'b1;
        end else if (irqClear) begin
            irqFlag <= 1'b0;
        end
    end

    assign irqOut = irqFlag && cfg.intEnable;

    // Flags a divider choice inside the recommended conversion clock window; advisory only.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clkRangeOk <= 1'b0;
        end else begin
            clkRangeOk <= ((32'h1 << cfg.divSel) >= adcs_pkg::MIN_CONV_CYCLES) &&
                          ((32'h1 << cfg.divSel) <= adcs_pkg::MAX_CONV_CYCLES);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            analog <= '0;
        end else begin
            analog.powerOn    <= cfg.powerEnable;
            analog.sampleHold <= (state == adcs_pkg::ST_SAMPLE);
            analog.dacCode    <= (state == adcs_pkg::ST_CONVERT) ? (sar | bit_mask(bitIdx)) : sar;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [adcs_pkg::TICK_CNT_WIDTH-1:0] convTicks;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            convTicks <= '0;
        end else if (trigger) begin
            convTicks <= '0;
        end else if (busyFlag && tick) begin
            convTicks <= convTicks + 5'h01;
        end
    end

    sequence seqStartPulse;
        startBit && !busyFlag && cfg.powerEnable ##1 !startBit && !busyFlag && cfg.powerEnable;
    endsequence

    sequence seqLastTick;
        (state == adcs_pkg::ST_CONVERT) && tick && (bitIdx == adcs_pkg::LSB_INDEX) && cfg.powerEnable;
    endsequence

    AST_PULSE_STARTS: assert property (@(posedge sys_clk) disable iff (!rstn)
        seqStartPulse |=> busyFlag && (state == adcs_pkg::ST_SAMPLE))
        else $error("a start pulse did not begin a conversion");
    AST_NO_START_WITHOUT_FALL: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(busyFlag) |-> $past(startBit, 2) && !$past(startBit))
        else $error("busy rose without a high then low start pulse");
    AST_DONE_CLEARS_BUSY: assert property (@(posedge sys_clk) disable iff (!rstn)
        seqLastTick |=> !busyFlag ##0 irqFlag)
        else $error("completion did not clear busy and raise the request");
    AST_IRQ_GATED: assert property (@(posedge sys_clk) disable iff (!rstn)
        seqLastTick |=> irqFlag && (irqOut == cfg.intEnable))
        else $error("completion did not raise the request or its gated interrupt");
    AST_SAMPLE_FOUR: assert property (@(posedge sys_clk) disable iff (!rstn)
        ($past(state) == adcs_pkg::ST_SAMPLE) && (state == adcs_pkg::ST_CONVERT) |->
            convTicks == adcs_pkg::SAMPLE_TICKS)
        else $error("sampling did not last four conversion clocks");
    AST_TOTAL_SIXTEEN: assert property (@(posedge sys_clk) disable iff (!rstn)
        seqLastTick |-> convTicks == adcs_pkg::TOTAL_TICKS - 5'h01)
        else $error("conversion did not last sixteen conversion clocks");
    AST_POWER_OFF_IDLE: assert property (@(posedge sys_clk) disable iff (!rstn)
        !cfg.powerEnable |=> (state == adcs_pkg::ST_IDLE) && !busyFlag && !analog.powerOn)
        else $error("converter active while power is off");
    AST_RESULT_HELD: assert property (@(posedge sys_clk) disable iff (!rstn)
        !busyFlag && $past(!busyFlag) |-> $stable(resultHigh) && $stable(resultLow))
        else $error("result bytes changed while not busy");
    AST_RESULT_WIDTH: assert property (@(posedge sys_clk) disable iff (!rstn)
        seqLastTick |=> ({resultHigh, resultLow} == (2 * adcs_pkg::BYTE_WIDTH)'(sar)))
        else $error("result bytes do not hold the twelve-bit code right-justified");
    AST_BUSY_IGNORES_START: assert property (@(posedge sys_clk) disable iff (!rstn)
        busyFlag && startBit && !done && cfg.powerEnable |=> busyFlag && (convTicks >= $past(convTicks)))
        else $error("a start pulse disturbed a running conversion");

endmodule // adcs_sequencer
`default_nettype wire

// file: adcs_pkg.sv
/*
 * Constants, types and timing figures shared by the converter sequencer and its clock divider.
 * Assumes a single system clock of 25 MHz and that software-facing control bits arrive on that clock.
 */
// Functional notes
// - A conversion starts only after the start bit goes high and then returns low.
// - The busy flag is set by hardware as soon as a conversion has been started.
// - The busy flag is cleared by hardware when the conversion finishes.
// - Completion sets the interrupt request flag, which reaches the interrupt line only when enabled.
// - The conversion clock is the system clock divided by 1, 2, 4 up to 128 for select codes 000 to 111.
// - The analog circuitry is powered only while the power-enable bit is high, which software sets first.
// - Each conversion first samples the input for exactly 4 conversion clocks.
// - Then 12 conversion clocks convert, giving 16 conversion clocks in all.
// - The result is held in a high and a low byte once the busy flag is low.
// - The result is 12 bits wide with all ones as full scale.
package adcs_pkg;

    // ****************************************************************
    // Widths and counts
    // ****************************************************************
    localparam int unsigned RESULT_WIDTH  = 12;
    localparam int unsigned BYTE_WIDTH    = 8;
    localparam int unsigned DIV_SEL_WIDTH = 3;
    localparam int unsigned DIV_CNT_WIDTH = 7;
    localparam int unsigned BIT_IDX_WIDTH = 4;
    localparam int unsigned TICK_CNT_WIDTH = 5;

    localparam logic [TICK_CNT_WIDTH-1:0] SAMPLE_TICKS  = 5'h04;
    localparam logic [TICK_CNT_WIDTH-1:0] CONVERT_TICKS = 5'h0c;
    localparam logic [TICK_CNT_WIDTH-1:0] TOTAL_TICKS   = 5'h10;
    localparam logic [BIT_IDX_WIDTH-1:0]  MSB_INDEX     = 4'hb;
    localparam logic [BIT_IDX_WIDTH-1:0]  LSB_INDEX     = 4'h0;
    localparam logic [RESULT_WIDTH-1:0]   FULL_SCALE    = 12'hfff;
    localparam logic [RESULT_WIDTH-1:0]   RESULT_RESET  = 12'h000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned SYS_CLK_PERIOD_NS  = 40;
    localparam int unsigned MIN_CONV_PERIOD_NS = 500;
    localparam int unsigned MAX_CONV_PERIOD_NS = 10000;
    localparam int unsigned MIN_CONV_CYCLES =
        (MIN_CONV_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned MAX_CONV_CYCLES = MAX_CONV_PERIOD_NS / SYS_CLK_PERIOD_NS;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h1,
        ST_SAMPLE  = 3'h2,
        ST_CONVERT = 3'h4
    } adcs_state_e;

    typedef struct packed {
        logic                     powerEnable;
        logic                     intEnable;
        logic [DIV_SEL_WIDTH-1:0] divSel;
    } adcs_cfg_s;

    typedef struct packed {
        logic                    powerOn;
        logic                    sampleHold;
        logic [RESULT_WIDTH-1:0] dacCode;
    } adcs_analog_s;

endpackage

// file: adcs_clk_div.sv
/*
 * Power-of-two divider that makes the one-cycle conversion clock tick from the system clock.
 * Assumes run is low between conversions so each conversion starts from a cleared count.
 */
`timescale 1ns/10ps
`default_nettype none
module adcs_clk_div (
    // Clock and reset
    input  wire logic                                 sys_clk,
    input  wire logic                                 rstn,
    // Control
    input  wire logic                                 run,
    input  wire logic [adcs_pkg::DIV_SEL_WIDTH-1:0]   divSel,
    // Tick
    output logic                                      tick
);

    logic [adcs_pkg::DIV_CNT_WIDTH-1:0] count;
    logic [adcs_pkg::DIV_CNT_WIDTH-1:0] wrapAt;

    function automatic logic [adcs_pkg::DIV_CNT_WIDTH-1:0] ratio_mask(
        input logic [adcs_pkg::DIV_SEL_WIDTH-1:0] sel);
        ratio_mask = adcs_pkg::DIV_CNT_WIDTH'((8'h01 << sel) - 8'h01);
    endfunction

    assign wrapAt = ratio_mask(divSel);
    assign tick   = run && (count == wrapAt);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (!run || tick) begin
            count <= '0;
        end else begin
            count <= count + 7'h01;
        end
    end

    AST_DIV_SPACING: assert property (@(posedge sys_clk) disable iff (!rstn)
        (run && tick && $past(run) && $stable(divSel)) |-> ($past(count) == wrapAt - 7'h01) || (wrapAt == '0))
        else $error("conversion clock tick spacing does not match the divider select");

endmodule // adcs_clk_div
`default_nettype wire

// file: test_adcs_sequencer.sv
/*
 * Self-checking testbench for the converter sequencer: start pulses, busy timing, interrupt flag, results.
 * Assumes the design package is compiled first and that the comparator answer may lag several system clocks.
 */
`timescale 1ns/10ps
`default_nettype none
module test_adcs_sequencer;

    // ****************************************************************
    // Signals
    // ****************************************************************
    typedef struct {
        int          len;
        int          sampLen;
        logic        irq;
        logic        rangeOk;
        logic        chkRes;
        logic [11:0] res;
    } adcs_exp_s;

    logic                                 sys_clk;
    logic                                 resetn;
    logic                                 startBit;
    logic                                 irqClear;
    logic                                 compIn;
    adcs_pkg::adcs_cfg_s                  cfg;
    logic                                 busyFlag;
    logic                                 irqFlag;
    logic                                 irqOut;
    logic                                 clkRangeOk;
    logic [adcs_pkg::BYTE_WIDTH-1:0]      resultHigh;
    logic [adcs_pkg::BYTE_WIDTH-1:0]      resultLow;
    adcs_pkg::adcs_analog_s               analog;
    logic [adcs_pkg::RESULT_WIDTH-1:0]    vin;
    logic [adcs_pkg::RESULT_WIDTH-1:0]    v;
    int                                   nFail;
    int                                   testsRun;
    int                                   busyLen;
    int                                   sampLen;
    adcs_exp_s                            expQ[$];

    adcs_sequencer uut (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .cfg        (cfg),
        .startBit   (startBit),
        .irqClear   (irqClear),
        .busyFlag   (busyFlag),
        .irqFlag    (irqFlag),
        .irqOut     (irqOut),
        .clkRangeOk (clkRangeOk),
        .resultHigh (resultHigh),
        .resultLow  (resultLow),
        .compIn     (compIn),
        .analog     (analog)
    );

    // ****************************************************************
    // Clock, analog input model and shared tasks
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // An ideal comparator against a held input level, so at divider select 3 and above the result must equal that level.
    always @(posedge sys_clk) begin
        compIn <= (vin >= analog.dacCode);
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
        testsRun++;
        if (seen !== expv) begin
            nFail++;
            $display("[FAIL] %s expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic complete_run();
        check("pending notes", 16'(expQ.size()), 16'h0);
        if (nFail == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************************************************************
    // Output monitor: each completed busy window consumes the oldest note.
    // ****************************************************************
    always @(negedge sys_clk) begin : monitor
        adcs_exp_s e;
        if (busyFlag === 1'b1) begin
            busyLen++;
            if (analog.sampleHold === 1'b1) sampLen++;
        end else if (busyLen > 0) begin
            if (expQ.size() == 0) begin
                check("unexpected conversion", 16'h1, 16'h0);
            end else begin
                e = expQ.pop_front();
                check("busy length", 16'(busyLen), 16'(e.len));
                if (e.sampLen > 0) check("sample length", 16'(sampLen), 16'(e.sampLen));
                check("irq flag", 16'(irqFlag), 16'(e.irq));
                check("clock range", 16'(clkRangeOk), 16'(e.rangeOk));
                if (e.chkRes) begin
                    check("result high", 16'(resultHigh), 16'({4'h0, e.res[11:8]}));
                    check("result low", 16'(resultLow), 16'(e.res[7:0]));
                end
            end
            busyLen = 0;
            sampLen = 0;
        end
    end

    // ****************************************************************
    // One conversion: optional long start high, retrigger while busy, or abort by power-off.
    // ****************************************************************
    task automatic run_conv(input logic [2:0] d, input logic ie, input logic [11:0] val,
                            input int hold, input bit retrig, input int abortK);
        adcs_exp_s e;
        int        r;
        int        n;
        r = 1 << d;
        e.len = (abortK > 0) ? abortK + 1 : 16 * r;
        e.sampLen = (abortK > 0) ? 0 : 4 * r;
        e.irq = (abortK == 0);
        e.rangeOk = (r >= 13 && r <= 250);
        // The synchronised comparator needs a few clocks per trial bit, so fast ratios skip the value check.
        e.chkRes = (abortK == 0 && d >= 3'h3);
        e.res = val;
        @(posedge sys_clk);
        cfg.divSel <= d;
        cfg.intEnable <= ie;
        vin <= val;
        startBit <= 1'b1;
        expQ.push_back(e);
        repeat (hold) begin
            @(posedge sys_clk);
            #1 check("busy while start high", 16'(busyFlag), 16'h0);
        end
        @(posedge sys_clk);
        startBit <= 1'b0;
        @(posedge sys_clk);
        #1 check("busy after trigger", 16'(busyFlag), 16'h1);
        if (retrig) begin
            repeat (5) @(posedge sys_clk);
            startBit <= 1'b1;
            @(posedge sys_clk);
            startBit <= 1'b0;
        end
        if (abortK > 0) begin
            repeat (abortK) @(posedge sys_clk);
            cfg.powerEnable <= 1'b0;
            repeat (2) @(posedge sys_clk);
            #1 check("busy after power-off", 16'(busyFlag), 16'h0);
            check("analog power off", 16'(analog.powerOn), 16'h0);
            @(posedge sys_clk);
            cfg.powerEnable <= 1'b1;
            repeat (20) @(posedge sys_clk);
            #1 check("analog power on", 16'(analog.powerOn), 16'h1);
        end else begin
            n = 0;
            while (busyFlag !== 1'b0 && n < 2100) begin
                @(posedge sys_clk);
                #1 n++;
            end
            check("busy cleared in time", 16'(busyFlag), 16'h0);
            check("irq line", 16'(irqOut), 16'(ie));
            repeat (3) @(posedge sys_clk);
            #1 check("busy stays low", 16'(busyFlag), 16'h0);
            @(posedge sys_clk);
            irqClear <= 1'b1;
            @(posedge sys_clk);
            irqClear <= 1'b0;
            #1 check("irq flag cleared", 16'(irqFlag), 16'h0);
        end
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        resetn = 1'b0;
        startBit = 1'b0;
        irqClear = 1'b0;
        cfg = '0;
        vin = '0;
        v = '0;
        nFail = 0;
        testsRun = 0;
        busyLen = 0;
        sampLen = 0;
        void'($urandom(32'h0a05962a));
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 check("reset busy", 16'(busyFlag), 16'h0);
        check("reset result", 16'({resultHigh, resultLow}), 16'h0);
        // A start pulse with the converter unpowered must be ignored.
        @(posedge sys_clk);
        startBit <= 1'b1;
        @(posedge sys_clk);
        startBit <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 check("busy unpowered", 16'(busyFlag), 16'h0);
        @(posedge sys_clk);
        cfg.powerEnable <= 1'b1;
        repeat (20) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            v = 12'($urandom);
            if (i == 3) v = 12'hfff;
            if (i == 4) v = 12'h000;
            run_conv(3'(i), 1'(i), v, (i == 1) ? 6 : 0, (i == 2), 0);
        end
        run_conv(3'h3, 1'b1, 12'h5a5, 0, 1'b0, 20);
        run_conv(3'h3, 1'b0, 12'h3c7, 0, 1'b0, 0);
        complete_run();
    end

    initial begin
        repeat (12000) @(posedge sys_clk);
        nFail++;
        complete_run();
    end

endmodule // test_adcs_sequencer
`default_nettype wire
